// *** hdl/stwc_top.sv ***
`timescale 1ns/100ps
`include "stwc_map.svh"

// Overview of operation
// - Bit 2 picks RC or external slow clock
// - Timer counts only while enable bit set
// - Coarse step: exponent 65536s, coarse 1s, fine 3.904ms
// - Fine step: exponent 512s, coarse 3.904ms, fine 30.5us
// - Coarse split high/low bytes, fine, exponent bits
// - Timer also gives periodic interrupt in run
// - Power-down select: run, light, deep, deepest
// - Status bit 6 shows crystal settled
// - Slow RC calibrated in run, value kept
// - Fast RC calibrated in run, value kept
// - Fast RC forced off in any sleep
// - Fast RC runs while its enable, reset 1
// - Slow RC runs while its enable, except in deepest, reset 1
// - All registers keep contents through sleep
// - Per-pin wake level, 0 low, 1 high
// - Per-pin wake mask enables pin wake
// - Per-pin pull enable and pull direction
// - Bit 7 enables brown-out detector, reset 1
// - Bit 6 enables analog regulators, reset 1
// - Status bit 2 enables analog input mux
// - Wake to run on pin, reset, and timer except in deepest
module stwc_top
    import stwc_pkg::*;
#(
    parameter int PORT_BITS = 24,       // Ports 0, 1 and 3 side by side
    parameter int CNT_W     = 34        // Widest interval in slow ticks
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 slowRcClkIn,
    input  wire logic                 extSlowClkIn,
    input  wire logic                 crystalOkIn,
    input  wire logic                 extResetWakeIn,
    input  wire logic [PORT_BITS-1:0] portPinIn,
    input  wire logic                 cpuSleepReq,
    input  wire logic [7:0]           fastRcCalCode,
    input  wire logic [7:0]           slowRcCalCode,
    output logic                      fastRcOscOn,
    output logic                      slowRcOscOn,
    output logic                      slowClockSel,
    output logic                      fastRcCalOn,
    output logic                      slowRcCalOn,
    output logic [7:0]                fastRcTrim,
    output logic [7:0]                slowRcTrim,
    output logic                      brownoutDetectEnable,
    output logic                      analogRegulatorEnable,
    output logic                      analogInputMuxEnable,
    output logic [PORT_BITS-1:0]      portPullOn,
    output logic [PORT_BITS-1:0]      portPullDirection,
    output logic [3:0]                powerState,
    output logic                      sleepTimerRunning,
    output logic                      sleepTimerIrq,
    output logic                      wakeEvent
);

    // Register storage, one byte per slot
    stwc_byte_t regFile [0:`STWC_NUM_SLOTS-1];

    // Bus address-phase capture
    logic                 wrPend_reg;     // Write data phase pending
    logic                 rdPend_reg;     // Read data phase pending
    logic [4:0]           slot_reg;       // Decoded slot
    logic                 hit_reg;        // Address mapped
    logic                 addrTake;       // Address phase accepted
    logic [13:0]          wordIdx;        // Word index from address
    logic                 addrHit;        // Index within the map
    logic [13:0]          slotWide;       // Index minus first index

    // Synchronisers for outside levels
    logic [1:0]           rcSync_reg;
    logic [1:0]           extSync_reg;
    logic [1:0]           xokSync_reg;
    logic [1:0]           rstWSync_reg;
    logic [PORT_BITS-1:0] pinMeta_reg;
    logic [PORT_BITS-1:0] pinSync_reg;
    logic                 tickPrev_reg;   // Last selected slow level
    logic                 slowLevel;      // Selected slow clock level
    logic                 slowTick;       // One rising slow-clock edge

    // Sleep timer
    logic [CNT_W-1:0]     count_reg;      // Elapsed slow ticks
    logic [CNT_W-1:0]     target;         // Programmed interval
    logic [15:0]          coarse;
    logic [1:0]           expo;
    logic                 timerOn;
    logic                 timerHit;

    // Power state and wake
    stwc_pstate_e         state_reg;
    stwc_pstate_e         state_next;
    logic [PORT_BITS-1:0] pinWake;
    logic                 wakeAny;
    logic                 inSleep;
    logic [PORT_BITS-1:0] wakeLevel;
    logic [PORT_BITS-1:0] wakeMask;

    // Reset value of a slot
    function automatic stwc_byte_t slotReset(input int s);
        case (s)
            `STWC_SLOT_PWR:   slotReset = `STWC_RST_PWR;
            `STWC_SLOT_CAL:   slotReset = `STWC_RST_CAL;
            `STWC_SLOT_LOW:   slotReset = `STWC_RST_LOW;
            `STWC_SLOT_STAT:  slotReset = `STWC_RST_STAT;
            `STWC_SLOT_WMSK3: slotReset = `STWC_RST_WMSK3;
            default: begin
                // Pull registers reset high, the rest to zero
                if (s >= `STWC_SLOT_PDIR0 && s < `STWC_SLOT_WLVL0)
                    slotReset = `STWC_RST_PULL;
                else
                    slotReset = `STWC_RST_ZERO;
            end
        endcase
    endfunction

    // Writable bits of a slot; read-only bits keep reset value
    function automatic stwc_byte_t slotMask(input logic [4:0] s);
        case (s)
            `STWC_SLOT_CAL:  slotMask = `STWC_WM_CAL;
            `STWC_SLOT_HOLE: slotMask = `STWC_WM_NONE;
            `STWC_SLOT_STAT: slotMask = `STWC_WM_STAT;
            default:         slotMask = `STWC_WM_ALL;
        endcase
    endfunction

    // Address decode of a transfer presented to this slave
    assign addrTake = hsel & hready & htrans[1];
    assign wordIdx  = haddr[15:2];
    assign slotWide = wordIdx - `STWC_IDX_PWR_CTRL;
    assign addrHit  = (haddr[31:16] == 16'h0000)
                    && (wordIdx >= `STWC_IDX_PWR_CTRL)
                    && (wordIdx <= `STWC_IDX_P3_WMSK)
                    && (wordIdx != `STWC_IDX_PWR_CTRL + 14'h0002);

    // Capture the address phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            slot_reg   <= 5'h00;
            hit_reg    <= 1'b0;
        end else if (rdPend_reg) begin
            // Wait state over, read completes
            rdPend_reg <= 1'b0;
        end else begin
            wrPend_reg <= addrTake & hwrite;
            rdPend_reg <= addrTake & ~hwrite;
            if (addrTake) begin
                slot_reg <= slotWide[4:0];
                hit_reg  <= addrHit;
            end
        end
    end

    // Reads take one wait state, writes none; always OKAY
    assign hreadyout = ~rdPend_reg;
    assign hresp     = 1'b0;

    // Read data, loaded in the wait state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rdPend_reg) begin
            if (!hit_reg) begin
                // Unmapped reads return zero
                hrdata <= 32'h0000_0000;
            end else if (slot_reg == `STWC_SLOT_STAT) begin
                hrdata <= {24'h00_0000, regFile[slot_reg]};
                hrdata[`STWC_ST_XOK] <= xokSync_reg[1];
            end else begin
                hrdata <= {24'h00_0000, regFile[slot_reg]};
            end
        end
    end

    // Register file; never cleared by power state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `STWC_NUM_SLOTS; i++) begin
                regFile[i] <= slotReset(i);
            end
        end else if (wrPend_reg && hit_reg) begin
            // Merge writable bits only
            regFile[slot_reg] <= (regFile[slot_reg] & ~slotMask(slot_reg))
                               | (hwdata[7:0] & slotMask(slot_reg));
        end
    end

    // Two-flop synchronisers for pins and analog status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rcSync_reg   <= 2'b00;
            extSync_reg  <= 2'b00;
            xokSync_reg  <= 2'b00;
            rstWSync_reg <= 2'b00;
            pinMeta_reg  <= '0;
            pinSync_reg  <= '0;
        end else begin
            rcSync_reg   <= {rcSync_reg[0], slowRcClkIn};
            extSync_reg  <= {extSync_reg[0], extSlowClkIn};
            xokSync_reg  <= {xokSync_reg[0], crystalOkIn};
            rstWSync_reg <= {rstWSync_reg[0], extResetWakeIn};
            pinMeta_reg  <= portPinIn;
            pinSync_reg  <= pinMeta_reg;
        end
    end

    // Slow clock source choice; the RC source needs its enable
    assign slowLevel = regFile[`STWC_SLOT_PWR][`STWC_PC_CLK_SEL]
                     ? extSync_reg[1]
                     : (rcSync_reg[1]
                        & regFile[`STWC_SLOT_PWR][`STWC_PC_SRC_ON]);

    // Rising-edge detect of the chosen slow clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickPrev_reg <= 1'b0;
        end else begin
            tickPrev_reg <= slowLevel;
        end
    end
    assign slowTick = slowLevel & ~tickPrev_reg;

    // Interval fields
    assign coarse = {regFile[`STWC_SLOT_HIGH], regFile[`STWC_SLOT_LOW]};
    assign expo   = regFile[`STWC_SLOT_STAT][`STWC_ST_EXP_HI:`STWC_ST_EXP_LO];

    // Interval in slow ticks for the selected step
    always_comb begin
        if (regFile[`STWC_SLOT_STAT][`STWC_ST_STEP]) begin
            target = CNT_W'(`STWC_TICKS_65536S * CNT_W'(expo))
                   + CNT_W'(`STWC_TICKS_SEC * CNT_W'(coarse))
                   + CNT_W'(`STWC_TICKS_MID
                            * CNT_W'(regFile[`STWC_SLOT_FINE]));
        end else begin
            target = CNT_W'(`STWC_TICKS_512S * CNT_W'(expo))
                   + CNT_W'(`STWC_TICKS_MID * CNT_W'(coarse))
                   + CNT_W'(`STWC_TICKS_FINE
                            * CNT_W'(regFile[`STWC_SLOT_FINE]));
        end
    end

    // Timer runs when enabled, except where it is powered down
    assign timerOn  = regFile[`STWC_SLOT_PWR][`STWC_PC_TMR_ON]
                    & (state_reg != STWC_DEEPEST);
    assign timerHit = timerOn & slowTick
                    & ((count_reg + CNT_W'(1)) >= target);

    // Elapsed tick counter, restarts after each interval
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (!timerOn) begin
            // Stopped timer holds at zero
            count_reg <= '0;
        end else if (timerHit) begin
            count_reg <= '0;
        end else if (slowTick) begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    // Timer interrupt pulse, in run, light and deep sleep alike
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleepTimerIrq <= 1'b0;
        end else begin
            sleepTimerIrq <= timerHit;
        end
    end

    // Pin wake match: enabled pins at their chosen level
    assign wakeLevel = {regFile[`STWC_SLOT_WLVL0+5'd2],
                        regFile[`STWC_SLOT_WLVL0+5'd1],
                        regFile[`STWC_SLOT_WLVL0]};
    assign wakeMask  = {regFile[`STWC_SLOT_WMSK3],
                        regFile[`STWC_SLOT_WMSK3-5'd1],
                        regFile[`STWC_SLOT_WMSK3-5'd2]};
    assign pinWake = wakeMask
                   & ~(pinSync_reg ^ wakeLevel);
    assign inSleep = (state_reg != STWC_RUN);
    assign wakeAny = (|pinWake) | timerHit | rstWSync_reg[1];

    // Next power state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            STWC_RUN: begin
                // Sleep request enters the programmed state
                if (cpuSleepReq) begin
                    case (regFile[`STWC_SLOT_PWR][`STWC_PC_MODE_HI:
                                                  `STWC_PC_MODE_LO])
                        2'b01:   state_next = STWC_LIGHT;
                        2'b10:   state_next = STWC_DEEP;
                        2'b11:   state_next = STWC_DEEPEST;
                        default: state_next = STWC_RUN;
                    endcase
                end
            end
            STWC_LIGHT, STWC_DEEP, STWC_DEEPEST: begin
                // Any wake source returns to run
                if (wakeAny) begin
                    state_next = STWC_RUN;
                end
            end
            default: state_next = STWC_RUN;
        endcase
    end

    // Power state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= STWC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Wake pulse marks the return to run
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wakeEvent <= 1'b0;
        end else begin
            wakeEvent <= inSleep & wakeAny;
        end
    end

    // Calibration trims follow the engines, then hold
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fastRcTrim <= 8'h00;
            slowRcTrim <= 8'h00;
        end else begin
            if (fastRcCalOn) begin
                fastRcTrim <= fastRcCalCode;
            end
            if (slowRcCalOn) begin
                slowRcTrim <= slowRcCalCode;
            end
        end
    end

    // Calibration active only in run with a settled crystal
    assign fastRcCalOn = ~inSleep & xokSync_reg[1]
                       & regFile[`STWC_SLOT_CAL][`STWC_CAL_FAST];
    assign slowRcCalOn = ~inSleep & xokSync_reg[1]
                       & regFile[`STWC_SLOT_CAL][`STWC_CAL_SLOW];

    // Oscillator gating
    assign fastRcOscOn = regFile[`STWC_SLOT_PWR][`STWC_PC_FRC_ON]
                       & ~inSleep;
    assign slowRcOscOn = regFile[`STWC_SLOT_PWR][`STWC_PC_SRC_ON]
                       & (state_reg != STWC_DEEPEST);
    assign slowClockSel = regFile[`STWC_SLOT_PWR][`STWC_PC_CLK_SEL];

    // Analog enables straight from the register bits
    assign brownoutDetectEnable  =
        regFile[`STWC_SLOT_PWR][`STWC_PC_BOD];
    assign analogRegulatorEnable =
        regFile[`STWC_SLOT_PWR][`STWC_PC_AREG];
    assign analogInputMuxEnable  =
        regFile[`STWC_SLOT_STAT][`STWC_ST_MUX];

    // Pull configuration, port 0 low byte, port 3 high byte
    assign portPullOn = {regFile[`STWC_SLOT_PON0+5'd2],
                         regFile[`STWC_SLOT_PON0+5'd1],
                         regFile[`STWC_SLOT_PON0]};
    assign portPullDirection = {regFile[`STWC_SLOT_PDIR0+5'd2],
                                regFile[`STWC_SLOT_PDIR0+5'd1],
                                regFile[`STWC_SLOT_PDIR0]};

    // Status outputs
    assign powerState        = state_reg;
    assign sleepTimerRunning = timerOn;

endmodule

// *** inc/stwc_map.svh ***
`ifndef STWC_MAP_SVH
`define STWC_MAP_SVH

// Register indices; the byte address is four times the index
`define STWC_IDX_PWR_CTRL   14'h22E0
`define STWC_IDX_RC_CAL     14'h22E1
`define STWC_IDX_INT_HIGH   14'h22E3
`define STWC_IDX_INT_LOW    14'h22E4
`define STWC_IDX_INT_FINE   14'h22E5
`define STWC_IDX_STEP_STAT  14'h22E6
`define STWC_IDX_P0_PDIR    14'h22E7
`define STWC_IDX_P1_PDIR    14'h22E8
`define STWC_IDX_P3_PDIR    14'h22E9
`define STWC_IDX_P0_PON     14'h22EA
`define STWC_IDX_P1_PON     14'h22EB
`define STWC_IDX_P3_PON     14'h22EC
`define STWC_IDX_P0_WLVL    14'h22ED
`define STWC_IDX_P1_WLVL    14'h22EE
`define STWC_IDX_P3_WLVL    14'h22EF
`define STWC_IDX_P0_WMSK    14'h22F0
`define STWC_IDX_P1_WMSK    14'h22F1
`define STWC_IDX_P3_WMSK    14'h22F2

// Slots relative to the first index
`define STWC_SLOT_PWR       5'd0
`define STWC_SLOT_CAL       5'd1
`define STWC_SLOT_HOLE      5'd2
`define STWC_SLOT_HIGH      5'd3
`define STWC_SLOT_LOW       5'd4
`define STWC_SLOT_FINE      5'd5
`define STWC_SLOT_STAT      5'd6
`define STWC_SLOT_PDIR0     5'd7
`define STWC_SLOT_PON0      5'd10
`define STWC_SLOT_WLVL0     5'd13
`define STWC_SLOT_WMSK3     5'd18
`define STWC_NUM_SLOTS      19

// Reset values
`define STWC_RST_PWR        8'hD8
`define STWC_RST_CAL        8'h98
`define STWC_RST_LOW        8'h01
`define STWC_RST_STAT       8'h87
`define STWC_RST_PULL       8'hFF
`define STWC_RST_WMSK3      8'h0C
`define STWC_RST_ZERO       8'h00

// Writable bit masks
`define STWC_WM_CAL         8'h6F
`define STWC_WM_STAT        8'h9F
`define STWC_WM_ALL         8'hFF
`define STWC_WM_NONE        8'h00

// Field positions, power-down control
`define STWC_PC_BOD         7
`define STWC_PC_AREG        6
`define STWC_PC_TMR_ON      5
`define STWC_PC_FRC_ON      4
`define STWC_PC_SRC_ON      3
`define STWC_PC_CLK_SEL     2
`define STWC_PC_MODE_HI     1
`define STWC_PC_MODE_LO     0
// Calibration and step/status fields
`define STWC_CAL_FAST       6
`define STWC_CAL_SLOW       3
`define STWC_ST_STEP        7
`define STWC_ST_XOK         6
`define STWC_ST_EXP_HI      4
`define STWC_ST_EXP_LO      3
`define STWC_ST_MUX         2

// Interval steps as printed, and their slow-clock tick counts
`define STWC_STEP_FINE_NS   30500
`define STWC_STEP_MID_NS    3904000
`define STWC_SLOW_HZ        32768
`define STWC_TICKS_FINE     34'h000000001
`define STWC_TICKS_MID      34'h000000080
`define STWC_TICKS_SEC      34'h000008000
`define STWC_TICKS_512S     34'h001000000
`define STWC_TICKS_65536S   34'h080000000

`endif

// *** inc/stwc_pkg.sv ***
package stwc_pkg;

    // Power states, one-hot
    typedef enum logic [3:0] {
        STWC_RUN     = 4'b0001,
        STWC_LIGHT   = 4'b0010,
        STWC_DEEP    = 4'b0100,
        STWC_DEEPEST = 4'b1000
    } stwc_pstate_e;

    // One register byte
    typedef logic [7:0] stwc_byte_t;

endpackage

// *** verification/stwc_monitor.sv ***
`timescale 1ns/100ps
// Watches the bus handshake and the power and timer outputs
module stwc_monitor
    import stwc_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       cpuSleepReq,
    input wire logic       fastRcOscOn,
    input wire logic       slowRcOscOn,
    input wire logic       fastRcCalOn,
    input wire logic       sleepTimerRunning,
    input wire logic       sleepTimerIrq,
    input wire logic       wakeEvent,
    input wire logic [3:0] powerState
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Transfers taken at an edge
    sequence rdTaken; hsel && hready && htrans[1] && !hwrite; endsequence
    sequence wrTaken; hsel && hready && htrans[1] && hwrite; endsequence
    a_read_one_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (wrTaken |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_state_onehot: assert property ($onehot(powerState))
        else $error("power state not one-hot");
    a_run_holds: assert property (
        powerState == STWC_RUN && !cpuSleepReq |=> powerState == STWC_RUN)
        else $error("left run without request");
    a_fast_rc_off: assert property (!powerState[0] |-> !fastRcOscOn)
        else $error("fast rc on in sleep");
    a_deepest_stop: assert property (
        powerState[3] |-> !sleepTimerRunning && !slowRcOscOn)
        else $error("timer alive in deepest");
    a_cal_run_only: assert property (fastRcCalOn |-> powerState[0])
        else $error("calibration outside run");
    a_irq_single: assert property (sleepTimerIrq |=> !sleepTimerIrq)
        else $error("timer pulse too long");
    a_wake_flag: assert property (
        $rose(powerState[0]) |-> ##[0:1] wakeEvent ##1 !wakeEvent)
        else $error("wake pulse missing");
endmodule

bind stwc_top stwc_monitor mon_u (.*);

// *** verification/stwc_top_test.sv ***
`timescale 1ns/100ps
`include "stwc_map.svh"
module stwc_top_test
    import stwc_pkg::*;
;
    logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        hreadyout, hresp, cpuSleepReq = 1'b0, crystalOkIn = 1'b0;
    logic        slowRcClkIn = 1'b0, extSlowClkIn = 1'b0;
    logic        extResetWakeIn = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic [23:0] portPinIn = 24'h0C0000, portPullOn, portPullDirection;
    logic [7:0]  fastRcCalCode = 8'h3C, slowRcCalCode = 8'h55;
    logic [7:0]  fastRcTrim, slowRcTrim;
    logic        fastRcOscOn, slowRcOscOn, slowClockSel, fastRcCalOn;
    logic        slowRcCalOn, brownoutDetectEnable, analogRegulatorEnable;
    logic        analogInputMuxEnable, sleepTimerRunning, sleepTimerIrq;
    logic        wakeEvent;
    logic [3:0]  powerState;
    int          error_cnt = 0, n_tests = 0, irqCnt = 0;
    // Rows: index, written byte, byte read back
    localparam logic [29:0] ROWS [9] = '{
        {`STWC_IDX_RC_CAL, 16'h0090}, {`STWC_IDX_RC_CAL, 16'hFFFF},
        {`STWC_IDX_STEP_STAT, 16'h0040}, {`STWC_IDX_STEP_STAT, 16'hFFDF},
        {14'h22E2, 16'hFF00}, {14'h22F3, 16'hFF00},
        {`STWC_IDX_P0_PDIR, 16'h5A5A}, {`STWC_IDX_P1_WLVL, 16'h5A5A},
        {`STWC_IDX_INT_FINE, 16'h3C3C}};
    // Reset values read after a reset in mid-run
    localparam logic [29:0] RSTV [11] = '{
        {`STWC_IDX_PWR_CTRL, 16'h00D8}, {`STWC_IDX_RC_CAL, 16'h0098},
        {`STWC_IDX_INT_HIGH, 16'h0000}, {`STWC_IDX_INT_LOW, 16'h0001},
        {`STWC_IDX_INT_FINE, 16'h0000}, {`STWC_IDX_STEP_STAT, 16'h00C7},
        {`STWC_IDX_P0_PDIR, 16'h00FF}, {`STWC_IDX_P3_PON, 16'h00FF},
        {`STWC_IDX_P1_WLVL, 16'h0000}, {`STWC_IDX_P0_WMSK, 16'h0000},
        {`STWC_IDX_P3_WMSK, 16'h000C}};

    stwc_top dut_u (.hready(hreadyout), .hsize(3'b010), .*);

    always #5 clk = ~clk;
    // Counts timer pulses
    always @(posedge clk) if (sleepTimerIrq === 1'b1) irqCnt++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic rdy;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) return;
        end
        error_cnt++;
        close_out();
    endtask
    // One single AHB transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [13:0] idx,
                       input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {16'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        rdy();
        rd = hrdata;
    endtask
    task automatic row(input logic [29:0] r, input logic w);
        if (w) bus(1'b1, r[29:16], r[15:8]);
        bus(1'b0, r[29:16], 8'h00);
        chk(rd, {24'h000000, r[7:0]});
    endtask
    // Slow clock edges on the chosen source, still between bursts
    task automatic ticks(input int n, input logic ext);
        repeat (n) begin
            repeat (10) @(posedge clk);
            if (ext) extSlowClkIn <= 1'b1;
            else slowRcClkIn <= 1'b1;
            repeat (10) @(posedge clk);
            extSlowClkIn <= 1'b0;
            slowRcClkIn <= 1'b0;
        end
        repeat (10) @(posedge clk);
    endtask
    // Selects a mode with regulators off, stays in run, requests sleep
    task automatic sleep(input logic [1:0] m, input logic [3:0] st);
        bus(1'b1, `STWC_IDX_PWR_CTRL, {6'b101110, m});
        repeat (3010) @(posedge clk);
        cpuSleepReq <= 1'b1;
        @(posedge clk);
        cpuSleepReq <= 1'b0;
        @(posedge clk);
        chk(powerState, st);
    endtask
    // Waits for the wake pulse, then checks the state is back in run
    task automatic wake;
        for (int i = 0; i < 20 && wakeEvent !== 1'b1; i++) @(posedge clk);
        chk(wakeEvent, 1'b1);
        chk(powerState, STWC_RUN);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, `STWC_IDX_STEP_STAT, 8'h00);
        chk(rd, 32'h87);
        crystalOkIn <= 1'b1;
        chk({fastRcOscOn, slowRcOscOn, sleepTimerRunning, brownoutDetectEnable,
             analogRegulatorEnable, analogInputMuxEnable, slowClockSel},
            7'b1101110);
        chk(portPullOn, 24'hFFFFFF);
        for (int i = 0; i < 9; i++) row(ROWS[i], 1'b1);
        chk(portPullDirection[7:0], 8'h5A);
        chk({fastRcTrim, slowRcTrim}, 16'h3C55);
        chk({fastRcCalOn, slowRcCalOn}, 2'b11);
        // Interval of three fine steps, above the shortest allowed
        bus(1'b1, `STWC_IDX_INT_FINE, 8'h03);
        bus(1'b1, `STWC_IDX_INT_LOW, 8'h00);
        bus(1'b1, `STWC_IDX_STEP_STAT, 8'h04);
        bus(1'b1, `STWC_IDX_PWR_CTRL, 8'hA8);
        @(posedge clk);
        chk(sleepTimerRunning, 1'b1);
        ticks(6, 1'b0);
        chk(irqCnt, 2);
        ticks(4, 1'b1);
        chk(irqCnt, 2);
        bus(1'b1, `STWC_IDX_PWR_CTRL, 8'hAC);
        ticks(6, 1'b1);
        chk(irqCnt, 4);
        chk(slowClockSel, 1'b1);
        // One fine byte on the coarse step is 128 slow ticks
        bus(1'b1, `STWC_IDX_STEP_STAT, 8'h84);
        bus(1'b1, `STWC_IDX_INT_FINE, 8'h01);
        ticks(127, 1'b1);
        chk(irqCnt, 4);
        ticks(1, 1'b1);
        chk(irqCnt, 5);
        bus(1'b1, `STWC_IDX_PWR_CTRL, 8'h0C);
        ticks(4, 1'b1);
        chk(irqCnt, 5);
        chk(brownoutDetectEnable, 1'b0);
        bus(1'b1, `STWC_IDX_STEP_STAT, 8'h04);
        bus(1'b1, `STWC_IDX_INT_FINE, 8'h03);
        // Pin wake on port 0 bit 0, high level
        bus(1'b1, `STWC_IDX_P0_WLVL, 8'h01);
        bus(1'b1, `STWC_IDX_P0_WMSK, 8'h01);
        sleep(2'b01, STWC_LIGHT);
        chk({fastRcOscOn, analogRegulatorEnable}, 2'b00);
        chk({fastRcCalOn, slowRcCalOn}, 2'b00);
        fastRcCalCode <= 8'h11;
        slowRcCalCode <= 8'h22;
        portPinIn[9] <= 1'b1;
        repeat (8) @(posedge clk);
        chk(powerState, STWC_LIGHT);
        chk({fastRcTrim, slowRcTrim}, 16'h3C55);
        portPinIn[0] <= 1'b1;
        wake();
        portPinIn[0] <= 1'b0;
        sleep(2'b00, STWC_RUN);
        sleep(2'b10, STWC_DEEP);
        ticks(3, 1'b0);
        chk(powerState, STWC_RUN);
        sleep(2'b11, STWC_DEEPEST);
        chk(sleepTimerRunning, 1'b0);
        extResetWakeIn <= 1'b1;
        wake();
        extResetWakeIn <= 1'b0;
        row({`STWC_IDX_P0_WMSK, 16'h0001}, 1'b0);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 11; i++) row(RSTV[i], 1'b0);
        close_out();
    end
endmodule
